// File: pmc_defines.svh
// Register offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_ADDR_W 8
`define PMC_DATA_W 8

`define PMC_ADDR_PCR0 8'h00
`define PMC_ADDR_PCR1 8'h01
`define PMC_ADDR_REGC 8'h02
`define PMC_ADDR_CLKSEL 8'h03
`define PMC_ADDR_PCLKEN 8'h04
`define PMC_ADDR_WSTAT 8'h05
`define PMC_ADDR_WMASK 8'h06
`define PMC_ADDR_MODE 8'h07

`define PMC_PCR0_IDLE 0
`define PMC_PCR0_STOP 1
`define PMC_PCR1_SUSPEND 0
`define PMC_PCR1_SNOOZE 1
`define PMC_REGC_STOPSEL 0
`define PMC_CLKSEL_SRC_LSB 0
`define PMC_CLKSEL_SRC_MSB 1
`define PMC_CLKSEL_DIV_LSB 4
`define PMC_CLKSEL_DIV_MSB 6
`define PMC_CLKSEL_T34SLOW 7

`define PMC_SRC_FAST24 2'h0
`define PMC_SRC_FAST49 2'h1
`define PMC_SRC_SLOW80 2'h2
`define PMC_SRC_EXT 2'h3

`define PMC_CLKSEL_RST 8'h30
`define PMC_PCLKEN_RST 8'hFF
`define PMC_REGC_RST 8'h00
`define PMC_WMASK_RST 8'h00

`define PMC_CLK_MHZ 20
`define PMC_OSC_START_NS 2000
`define PMC_OSC_START_CYC ((`PMC_OSC_START_NS * `PMC_CLK_MHZ + 999) / 1000)

`endif

// File: pmc_pkg.sv
// Types shared by the power-mode controller modules
package pmc_pkg;
	typedef enum logic [7:0] {
		ST_NORMAL = 8'h01,
		ST_IDLE = 8'h02,
		ST_SUSPEND = 8'h04,
		ST_SNOOZE = 8'h08,
		ST_STOP = 8'h10,
		ST_SHUTDOWN = 8'h20,
		ST_WAKEUP = 8'h40,
		ST_RSTEXIT = 8'h80
	} pmc_state_t;

	typedef struct packed {
		logic clu_evt;
		logic cmp0_lvl;
		logic port_match;
		logic i2c_act;
		logic spi_act;
		logic timer4_evt;
	} pmc_wake_t;

	typedef struct packed {
		logic pin;
		logic por;
		logic other;
	} pmc_rstsrc_t;
endpackage

// File: pmc_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module pmc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule // pmc_sync

// File: pmc_clkdiv.sv
// System clock divider: tick once per 1..128 source cycles
`timescale 1ns/1ps
module pmc_clkdiv (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [2:0] i_div_sel,
	output logic o_tick
);
	logic [6:0] cnt_ff;
	logic tick_ff;
	wire [6:0] div_mask = 7'((8'h01 << i_div_sel) - 8'h01);
	wire hit = (cnt_ff & div_mask) == div_mask;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_ff <= 7'h00;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= hit ? 7'h00 : 7'(cnt_ff + 7'h01);
			tick_ff <= hit;
		end
	end

	assign o_tick = tick_ff;

	a_div_by_one: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_div_sel == 3'h0) && ($past(i_div_sel) == 3'h0) |=> o_tick)
		else $error("divide-by-one does not tick every cycle");
	a_div_by_two: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_div_sel == 3'h1) [*4] |-> (o_tick != $past(o_tick)))
		else $error("divide-by-two tick does not alternate");
endmodule // pmc_clkdiv

// File: pmc_power_mode_controller.sv
// Power-mode sequencer with register port, wake logic, clock gating and divider
//
// Behaviour
// - Normal mode clocks core and the peripherals enabled in PCLKEN.
// - Idle bit halts core, peripherals keep running.
// - Any interrupt wakes idle; execution resumes.
// - Suspend stops clocks, fast oscillators; normal bias.
// - Timers 3, 4 may count from 80 kHz.
// - Listed peripheral events wake suspend or snooze.
// - Stop powers down, pins held, any reset exits.
// - Snooze stops clocks, fast oscillators; regulator low bias.
// - Shutdown exits only on pin or power-on reset.
// - Unused digital peripheral clocks are gated off.
// - Reset default clock is 24.5 MHz divided by 8.
// - Divider offers divide by 1 to 128.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_power_mode_controller (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [`PMC_ADDR_W-1:0] i_addr,
	input wire logic [`PMC_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`PMC_DATA_W-1:0] o_rdata,
	input wire logic i_irq_any,
	input wire pmc_pkg::pmc_wake_t i_wake_pins,
	input wire logic i_reset_pin_n,
	input wire logic i_por,
	input wire logic i_other_rst,
	output logic o_core_clk_en,
	output logic [7:0] o_periph_clk_en,
	output logic o_fast_osc_24m_en,
	output logic o_fast_osc_49m_en,
	output logic o_slow_osc_80k_en,
	output logic o_reg_low_bias,
	output logic o_power_nets_on,
	output logic o_pin_hold,
	output logic o_timer34_slow_en,
	output logic [1:0] o_system_clock_source,
	output logic o_system_clock_source_tick,
	output logic o_core_reset,
	output logic o_irq
);
	import pmc_pkg::*;

	localparam logic [7:0] WAKE_CYC = 8'(`PMC_OSC_START_CYC);

	pmc_state_t state_ff;
	pmc_state_t nxt_state;
	logic [7:0] regc_ff;
	logic [7:0] clksel_ff;
	logic [7:0] pclken_ff;
	logic [7:0] wstat_ff;
	logic [7:0] wmask_ff;
	logic [7:0] rdata_ff;
	logic [7:0] wake_cnt_ff;
	logic cmp0_prev_ff;
	logic irq_ff;
	logic core_en_ff;
	logic [7:0] periph_en_ff;
	logic fast24_ff;
	logic fast49_ff;
	logic slow80_ff;
	logic low_bias_ff;
	logic power_on_ff;
	logic pin_hold_ff;
	logic t34_ff;
	logic core_rst_ff;

	pmc_wake_t wake_s;
	pmc_rstsrc_t rst_s;
	logic [8:0] sync_out;

	// Reset pin is inverted ahead of the synchroniser so its cleared state means no reset
	pmc_sync #(
		.WIDTH(9)
	) u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_async({~i_reset_pin_n, i_por, i_other_rst, i_wake_pins}),
		.o_sync(sync_out)
	);

	assign rst_s = sync_out[8:6];
	assign wake_s = sync_out[5:0];

	pmc_clkdiv u_div (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_div_sel(clksel_ff[`PMC_CLKSEL_DIV_MSB:`PMC_CLKSEL_DIV_LSB]),
		.o_tick(o_system_clock_source_tick)
	);

	// Register decode
	wire wr_pcr0 = i_wr && (i_addr == `PMC_ADDR_PCR0);
	wire wr_pcr1 = i_wr && (i_addr == `PMC_ADDR_PCR1);
	wire wr_regc = i_wr && (i_addr == `PMC_ADDR_REGC);
	wire wr_clksel = i_wr && (i_addr == `PMC_ADDR_CLKSEL);
	wire wr_pclken = i_wr && (i_addr == `PMC_ADDR_PCLKEN);
	wire wr_wstat = i_wr && (i_addr == `PMC_ADDR_WSTAT);
	wire wr_wmask = i_wr && (i_addr == `PMC_ADDR_WMASK);

	wire req_idle = wr_pcr0 && i_wdata[`PMC_PCR0_IDLE];
	wire req_stop = wr_pcr0 && i_wdata[`PMC_PCR0_STOP];
	wire req_suspend = wr_pcr1 && i_wdata[`PMC_PCR1_SUSPEND];
	wire req_snooze = wr_pcr1 && i_wdata[`PMC_PCR1_SNOOZE];
	wire stop_sel = regc_ff[`PMC_REGC_STOPSEL];

	// Wake sources; comparator falls are seen on the synchronised level only
	wire cmp0_fall = cmp0_prev_ff && !wake_s.cmp0_lvl;
	wire [5:0] wake_ev = {wake_s.clu_evt, cmp0_fall, wake_s.port_match,
		wake_s.i2c_act, wake_s.spi_act, wake_s.timer4_evt};
	wire lp_wake = |wake_ev;
	wire any_rst = rst_s.pin || rst_s.por || rst_s.other;
	wire hard_rst = rst_s.pin || rst_s.por;

	wire low_mode = (state_ff == ST_SUSPEND) || (state_ff == ST_SNOOZE);
	wire [7:0] wstat_clr = wr_wstat ? i_wdata : 8'h00;
	// A wake event landing on the clearing write stays set
	wire [7:0] nxt_wstat = (wstat_ff & ~wstat_clr) | {2'h0, wake_ev};

	wire [7:0] pcr0_rd = {6'h00, (state_ff == ST_STOP) || (state_ff == ST_SHUTDOWN), state_ff == ST_IDLE};
	wire [7:0] pcr1_rd = {6'h00, state_ff == ST_SNOOZE, state_ff == ST_SUSPEND};
	wire [7:0] rd_mux =
		(i_addr == `PMC_ADDR_PCR0) ? pcr0_rd :
		(i_addr == `PMC_ADDR_PCR1) ? pcr1_rd :
		(i_addr == `PMC_ADDR_REGC) ? regc_ff :
		(i_addr == `PMC_ADDR_CLKSEL) ? clksel_ff :
		(i_addr == `PMC_ADDR_PCLKEN) ? pclken_ff :
		(i_addr == `PMC_ADDR_WSTAT) ? wstat_ff :
		(i_addr == `PMC_ADDR_WMASK) ? wmask_ff :
		(i_addr == `PMC_ADDR_MODE) ? 8'(state_ff) : 8'h00;

	// Mode sequencing; stop outranks suspend, snooze and idle when written together
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_NORMAL: begin
				if (any_rst) begin
					nxt_state = ST_RSTEXIT;
				end else if (req_stop) begin
					nxt_state = stop_sel ? ST_SHUTDOWN : ST_STOP;
				end else if (req_suspend) begin
					nxt_state = ST_SUSPEND;
				end else if (req_snooze) begin
					nxt_state = ST_SNOOZE;
				end else if (req_idle) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (any_rst) begin
					nxt_state = ST_RSTEXIT;
				end else if (i_irq_any || irq_ff) begin
					nxt_state = ST_NORMAL;
				end
			end
			ST_SUSPEND, ST_SNOOZE: begin
				if (any_rst) begin
					nxt_state = ST_RSTEXIT;
				end else if (lp_wake) begin
					nxt_state = ST_WAKEUP;
				end
			end
			ST_STOP: begin
				if (any_rst) begin
					nxt_state = ST_RSTEXIT;
				end
			end
			ST_SHUTDOWN: begin
				if (hard_rst) begin
					nxt_state = ST_RSTEXIT;
				end
			end
			ST_WAKEUP: begin
				if (any_rst) begin
					nxt_state = ST_RSTEXIT;
				end else if (wake_cnt_ff == 8'h00) begin
					nxt_state = ST_NORMAL;
				end
			end
			ST_RSTEXIT: begin
				nxt_state = ST_NORMAL;
			end
			default: begin
				nxt_state = ST_NORMAL;
			end
		endcase
	end

	wire nxt_run = (nxt_state == ST_NORMAL) || (nxt_state == ST_IDLE);
	wire nxt_off = (nxt_state == ST_STOP) || (nxt_state == ST_SHUTDOWN);
	wire nxt_low = (nxt_state == ST_SUSPEND) || (nxt_state == ST_SNOOZE);
	wire nxt_core_en = nxt_state == ST_NORMAL;
	wire [7:0] nxt_periph_en = nxt_run ? pclken_ff : 8'h00;
	// The 24.5 MHz oscillator runs whenever the part is awake so a wake never waits on it twice
	wire nxt_fast24 = !nxt_low && !nxt_off;
	wire nxt_fast49 = nxt_run && (clksel_ff[`PMC_CLKSEL_SRC_MSB:`PMC_CLKSEL_SRC_LSB] == `PMC_SRC_FAST49);
	wire nxt_low_bias = nxt_state == ST_SNOOZE;
	wire nxt_t34 = nxt_low && clksel_ff[`PMC_CLKSEL_T34SLOW];
	wire [7:0] nxt_wake_cnt = ((nxt_state == ST_WAKEUP) && (state_ff != ST_WAKEUP)) ? 8'(WAKE_CYC - 8'h01) :
		(wake_cnt_ff != 8'h00) ? 8'(wake_cnt_ff - 8'h01) : 8'h00;
	// A reset exit puts the clock back to its default, whatever software had chosen
	wire [7:0] nxt_clksel = (state_ff == ST_RSTEXIT) ? `PMC_CLKSEL_RST :
		wr_clksel ? i_wdata : clksel_ff;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_ff <= ST_NORMAL;
			wake_cnt_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			wake_cnt_ff <= nxt_wake_cnt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			regc_ff <= `PMC_REGC_RST;
			clksel_ff <= `PMC_CLKSEL_RST;
			pclken_ff <= `PMC_PCLKEN_RST;
			wmask_ff <= `PMC_WMASK_RST;
			wstat_ff <= 8'h00;
			rdata_ff <= 8'h00;
		end else begin
			regc_ff <= wr_regc ? i_wdata : regc_ff;
			clksel_ff <= nxt_clksel;
			pclken_ff <= wr_pclken ? i_wdata : pclken_ff;
			wmask_ff <= wr_wmask ? i_wdata : wmask_ff;
			wstat_ff <= nxt_wstat;
			rdata_ff <= i_rd ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cmp0_prev_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			cmp0_prev_ff <= wake_s.cmp0_lvl;
			irq_ff <= |(wstat_ff & wmask_ff);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			core_en_ff <= 1'b1;
			periph_en_ff <= `PMC_PCLKEN_RST;
			fast24_ff <= 1'b1;
			fast49_ff <= 1'b0;
			slow80_ff <= 1'b1;
			low_bias_ff <= 1'b0;
			power_on_ff <= 1'b1;
			pin_hold_ff <= 1'b0;
			t34_ff <= 1'b0;
			core_rst_ff <= 1'b0;
		end else begin
			core_en_ff <= nxt_core_en;
			periph_en_ff <= nxt_periph_en;
			fast24_ff <= nxt_fast24;
			fast49_ff <= nxt_fast49;
			slow80_ff <= !nxt_off;
			low_bias_ff <= nxt_low_bias;
			power_on_ff <= !nxt_off;
			pin_hold_ff <= nxt_off;
			t34_ff <= nxt_t34;
			core_rst_ff <= nxt_state == ST_RSTEXIT;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_core_clk_en = core_en_ff;
	assign o_periph_clk_en = periph_en_ff;
	assign o_fast_osc_24m_en = fast24_ff;
	assign o_fast_osc_49m_en = fast49_ff;
	assign o_slow_osc_80k_en = slow80_ff;
	assign o_reg_low_bias = low_bias_ff;
	assign o_power_nets_on = power_on_ff;
	assign o_pin_hold = pin_hold_ff;
	assign o_timer34_slow_en = t34_ff;
	assign o_system_clock_source = clksel_ff[`PMC_CLKSEL_SRC_MSB:`PMC_CLKSEL_SRC_LSB];
	assign o_core_reset = core_rst_ff;
	assign o_irq = irq_ff;

	a_normal_core_clock: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_NORMAL) |-> o_core_clk_en && (o_periph_clk_en == $past(pclken_ff)))
		else $error("normal mode core or peripheral clocks wrong");
	a_idle_entry_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_NORMAL) && req_idle && !req_stop && !wr_pcr1 && !any_rst
		|=> (state_ff == ST_IDLE) && !o_core_clk_en && (o_periph_clk_en == pclken_ff))
		else $error("idle entry did not halt core only");
	a_idle_irq_wake: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_IDLE) && i_irq_any && !any_rst |=> (state_ff == ST_NORMAL) && o_core_clk_en)
		else $error("idle did not wake on interrupt");
	a_suspend_outputs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_SUSPEND) |-> !o_core_clk_en && (o_periph_clk_en == 8'h00)
		&& !o_fast_osc_24m_en && !o_fast_osc_49m_en && !o_reg_low_bias)
		else $error("suspend outputs wrong");
	a_timer_slow_clock: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		low_mode && $stable(clksel_ff) |-> (o_timer34_slow_en == clksel_ff[`PMC_CLKSEL_T34SLOW]))
		else $error("timer slow clock enable wrong in low-power mode");
	a_lp_wake_start: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		low_mode && lp_wake && !any_rst |=> (state_ff == ST_WAKEUP) && o_fast_osc_24m_en)
		else $error("wake event ignored in low-power mode");
	a_stop_reset_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_STOP) && any_rst |=> o_core_reset && o_power_nets_on ##1 (state_ff == ST_NORMAL))
		else $error("stop did not exit on reset source");
	a_snooze_low_bias: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_SNOOZE) |-> o_reg_low_bias && !o_fast_osc_24m_en && !o_core_clk_en)
		else $error("snooze outputs wrong");
	a_shutdown_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_SHUTDOWN) && !hard_rst |=> (state_ff == ST_SHUTDOWN) && o_pin_hold && !o_power_nets_on)
		else $error("shutdown left without pin or power-on reset");
	a_reset_clock_default: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$past(state_ff) == ST_RSTEXIT |-> (clksel_ff == `PMC_CLKSEL_RST))
		else $error("clock not default after reset exit");
	a_stop_select_sample: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_NORMAL) && req_stop && !any_rst |=> (state_ff == ($past(stop_sel) ? ST_SHUTDOWN : ST_STOP)))
		else $error("stop select not honoured");
	a_wake_clock_order: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_ff == ST_WAKEUP) |-> o_fast_osc_24m_en && !o_core_clk_en && (o_periph_clk_en == 8'h00))
		else $error("clocks enabled before oscillator restart done");
	a_wake_lasts_40: assert property (@(posedge i_mclk) disable iff (!i_rst_n || any_rst)
		low_mode && lp_wake |=> (state_ff == ST_WAKEUP) ##39 (state_ff == ST_WAKEUP) ##1 (state_ff == ST_NORMAL))
		else $error("oscillator restart time wrong");
endmodule // pmc_power_mode_controller

// File: pmc_power_mode_controller_tb.sv
// Self-checking testbench of the power-mode controller
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_power_mode_controller_tb;
	import pmc_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_irq_any = 1'b0;
	logic [5:0] wake_lvl = 6'h00;
	logic i_reset_pin_n = 1'b1;
	logic i_por = 1'b0;
	logic i_other_rst = 1'b0;
	logic [7:0] o_rdata;
	logic [7:0] o_periph_clk_en;
	logic [1:0] o_system_clock_source;
	logic o_core_clk_en, o_fast_osc_24m_en, o_fast_osc_49m_en, o_slow_osc_80k_en, o_reg_low_bias;
	logic o_power_nets_on, o_pin_hold, o_timer34_slow_en, o_system_clock_source_tick, o_core_reset, o_irq;
	int n_mismatch = 0;
	int num_checks = 0;

	always #25 i_mclk = ~i_mclk;

	pmc_power_mode_controller i_dut (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_irq_any(i_irq_any), .i_wake_pins(pmc_wake_t'(wake_lvl)),
		.i_reset_pin_n(i_reset_pin_n), .i_por(i_por), .i_other_rst(i_other_rst),
		.o_core_clk_en(o_core_clk_en), .o_periph_clk_en(o_periph_clk_en),
		.o_fast_osc_24m_en(o_fast_osc_24m_en), .o_fast_osc_49m_en(o_fast_osc_49m_en),
		.o_slow_osc_80k_en(o_slow_osc_80k_en), .o_reg_low_bias(o_reg_low_bias),
		.o_power_nets_on(o_power_nets_on), .o_pin_hold(o_pin_hold), .o_timer34_slow_en(o_timer34_slow_en),
		.o_system_clock_source(o_system_clock_source), .o_system_clock_source_tick(o_system_clock_source_tick),
		.o_core_reset(o_core_reset), .o_irq(o_irq)
	);

	function automatic logic [7:0] b(input logic v);
		return {7'h00, v};
	endfunction

	task automatic tick;
		@(posedge i_mclk);
		#1;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Strobe drops and one edge passes, so back-to-back calls never reassign it in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		tick;
		i_wr <= 1'b0;
		tick;
	endtask

	task automatic rd_expect(input logic [7:0] a, input logic [7:0] exp);
		i_addr <= a;
		i_rd <= 1'b1;
		tick;
		i_rd <= 1'b0;
		check(o_rdata, exp);
		tick;
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wait_awake(output int cyc);
		cyc = 0;
		while (!(o_core_clk_en === 1'b1 && o_power_nets_on === 1'b1) && cyc < 200) begin
			tick;
			cyc++;
		end
		if (cyc >= 200) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
			tally_and_finish;
		end
	endtask

	task automatic t_reset;
		check(b(o_core_clk_en), 8'h01);
		check(o_periph_clk_en, 8'hFF);
		check({6'h00, o_system_clock_source}, 8'h00);
		rd_expect(`PMC_ADDR_CLKSEL, 8'h30);
		rd_expect(`PMC_ADDR_PCLKEN, 8'hFF);
		rd_expect(`PMC_ADDR_REGC, 8'h00);
		rd_expect(`PMC_ADDR_WMASK, 8'h00);
		wr(`PMC_ADDR_MODE, 8'h02);
		rd_expect(`PMC_ADDR_MODE, 8'h01);
		rd_expect(8'h0F, 8'h00);
		wr(`PMC_ADDR_PCLKEN, 8'h5A);
		check(o_periph_clk_en, 8'h5A);
		wr(`PMC_ADDR_PCLKEN, 8'hFF);
		$display("test reset done");
	endtask

	task automatic t_divider;
		int d, k, cnt;
		for (d = 0; d < 8; d++) begin
			wr(`PMC_ADDR_CLKSEL, 8'(d << 4));
			// First gap may be partial after a change, so the third one is measured
			for (k = 0; k < 3; k++) begin
				cnt = 0;
				do begin
					tick;
					cnt++;
				end while (o_system_clock_source_tick !== 1'b1 && cnt < 300);
				if (cnt >= 300) begin
					check(8'(cnt), 8'(1 << d));
					tally_and_finish;
				end
			end
			check(8'(cnt), 8'(1 << d));
		end
		wr(`PMC_ADDR_CLKSEL, 8'h31);
		check({6'h00, o_system_clock_source}, 8'h01);
		check(b(o_fast_osc_49m_en), 8'h01);
		wr(`PMC_ADDR_CLKSEL, 8'h30);
		$display("test divider done");
	endtask

	task automatic t_idle;
		int cyc;
		wr(`PMC_ADDR_PCR0, 8'h01);
		check(b(o_core_clk_en), 8'h00);
		check(o_periph_clk_en, 8'hFF);
		rd_expect(`PMC_ADDR_MODE, 8'h02);
		wr(`PMC_ADDR_PCR1, 8'h01);
		rd_expect(`PMC_ADDR_MODE, 8'h02);
		i_irq_any <= 1'b1;
		wait_awake(cyc);
		i_irq_any <= 1'b0;
		rd_expect(`PMC_ADDR_MODE, 8'h01);
		$display("test idle done");
	endtask

	task automatic t_lowpower;
		int m, i, cyc;
		wr(`PMC_ADDR_CLKSEL, 8'h80);
		for (m = 0; m < 2; m++) begin
			for (i = 0; i < 6; i++) begin
				wr(`PMC_ADDR_WMASK, (i % 2 == 0) ? 8'(1 << i) : 8'h00);
				wake_lvl <= (i == 4) ? 6'h10 : 6'h00;
				wr(`PMC_ADDR_PCR1, (m == 1) ? 8'h02 : 8'h01);
				check(b(o_core_clk_en), 8'h00);
				check(o_periph_clk_en, 8'h00);
				check(b(o_fast_osc_24m_en | o_fast_osc_49m_en), 8'h00);
				check(b(o_reg_low_bias), 8'(m));
				check(b(o_slow_osc_80k_en & o_timer34_slow_en), 8'h01);
				rd_expect(`PMC_ADDR_MODE, (m == 1) ? 8'h08 : 8'h04);
				wake_lvl <= (i == 4) ? 6'h00 : 6'(1 << i);
				repeat (3) tick;
				wake_lvl <= 6'h00;
				wait_awake(cyc);
				check(8'(cyc), 8'(`PMC_OSC_START_CYC));
				check(b(o_fast_osc_24m_en), 8'h01);
				check(o_periph_clk_en, 8'hFF);
				rd_expect(`PMC_ADDR_WSTAT, 8'(1 << i));
				check(b(o_irq), b(i % 2 == 0));
				wr(`PMC_ADDR_WSTAT, 8'(1 << i));
				tick;
				check(b(o_irq), 8'h00);
				rd_expect(`PMC_ADDR_WSTAT, 8'h00);
			end
		end
		$display("test low power done");
	endtask

	task automatic t_shutdown;
		int j, cyc;
		for (j = 0; j < 2; j++) begin
			wr(`PMC_ADDR_REGC, 8'h01);
			wr(`PMC_ADDR_PCR0, 8'h02);
			check(b(o_power_nets_on), 8'h00);
			rd_expect(`PMC_ADDR_MODE, 8'h20);
			i_other_rst <= 1'b1;
			repeat (3) tick;
			i_other_rst <= 1'b0;
			repeat (10) tick;
			check(b(o_power_nets_on), 8'h00);
			check(b(o_pin_hold), 8'h01);
			if (j == 0) i_reset_pin_n <= 1'b0;
			else i_por <= 1'b1;
			repeat (3) tick;
			i_reset_pin_n <= 1'b1;
			i_por <= 1'b0;
			wait_awake(cyc);
			repeat (6) tick;
			rd_expect(`PMC_ADDR_MODE, 8'h01);
		end
		$display("test shutdown done");
	endtask

	task automatic t_stop;
		int cyc;
		wr(`PMC_ADDR_CLKSEL, 8'h05);
		wr(`PMC_ADDR_REGC, 8'h00);
		wr(`PMC_ADDR_PCR0, 8'h02);
		check(b(o_power_nets_on), 8'h00);
		check(b(o_pin_hold), 8'h01);
		rd_expect(`PMC_ADDR_MODE, 8'h10);
		i_other_rst <= 1'b1;
		repeat (3) tick;
		check(b(o_core_reset), 8'h01);
		i_other_rst <= 1'b0;
		wait_awake(cyc);
		repeat (6) tick;
		rd_expect(`PMC_ADDR_MODE, 8'h01);
		check(b(o_pin_hold), 8'h00);
		rd_expect(`PMC_ADDR_CLKSEL, 8'h30);
		$display("test stop done");
	endtask

	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		tick;
		t_reset;
		t_divider;
		t_idle;
		t_lowpower;
		t_shutdown;
		t_stop;
		tally_and_finish;
	end
endmodule // pmc_power_mode_controller_tb
